// [dcap_ctl.sv]
/*
 dcap_ctl: behavioural memory controller driving the dram pins of dcap_top.
 assumes: link_ck comes from the bench; the bench calls the tasks one at a time.
*/
module dcap_ctl
(
   input wire logic link_ck,
   output logic cke,
   output logic cs_n,
   output logic ras_n,
   output logic cas_n,
   output logic we_n,
   output logic [2:0] ba,
   output logic [15:0] addr,
   output logic [7:0] dq_i,
   output logic dqs_i,
   input wire logic [7:0] dq_o,
   input wire logic dq_oe
);
   timeunit 1ns;
   timeprecision 100ps;
   initial
   begin
      cke = 1'b1;
      {cs_n, ras_n, cas_n, we_n} = 4'b0111;
      ba = 3'h0;
      addr = 16'h0000;
      dq_i = 8'h00;
      dqs_i = 1'b0;
   end
   // pins move at the fall so they are settled at the sampling rise
   task cmd(input logic [3:0] c, input logic [2:0] b, input logic [15:0] a);
      @(negedge link_ck);
      {cs_n, ras_n, cas_n, we_n} = c;
      ba = b;
      addr = a;
      @(negedge link_ck);
      {cs_n, ras_n, cas_n, we_n} = 4'b0111;
      ba = ~b;
      addr = ~a;
   endtask : cmd
   // beats change a quarter cycle away from both sampling edges
   task wr(input logic [2:0] b, input logic [15:0] a, input logic [7:0] d [8]);
      cmd(4'b0100, b, a);
      // the first even beat is sampled cwl + 1 rises after the command
      repeat (4) @(negedge link_ck);
      for (int i = 0; i < 4; i++)
      begin
         @(negedge link_ck);
         #12;
         dq_i = d[2*i];
         dqs_i = 1'b0;
         @(posedge link_ck);
         #12;
         dq_i = d[2*i+1];
         dqs_i = 1'b1;
      end
      @(negedge link_ck);
      #12;
      // released bus shows the inverse so a stale sample cannot match
      dq_i = ~d[7];
      dqs_i = 1'b0;
   endtask : wr
   task rd(input logic [2:0] b, input logic [15:0] a, input int frz, output int lat,
      output int n, output logic [7:0] w [16]);
      int fl;
      logic [7:0] h;
      fl = 0;
      lat = 0;
      n = 0;
      cmd(4'b0101, b, a);
      for (int k = 1; k < 25; k++)
      begin
         @(posedge link_ck);
         #12;
         h = dq_o;
         if (dq_oe === 1'b1 && lat == 0)
            lat = k;
         @(negedge link_ck);
         #12;
         if (dq_oe === 1'b1 && n < 15)
         begin
            w[n] = h;
            w[n+1] = dq_o;
            n = n + 2;
         end
         if (k == lat && frz > 0)
            fl = frz;
         cke = (fl == 0);
         if (fl > 0)
            fl--;
      end
   endtask : rd
   task sleep(input logic [3:0] c);
      @(negedge link_ck);
      cke = 1'b0;
      {cs_n, ras_n, cas_n, we_n} = c;
      @(negedge link_ck);
      {cs_n, ras_n, cas_n, we_n} = 4'b0111;
   endtask : sleep
   task wake();
      @(negedge link_ck);
      cke = 1'b1;
      repeat (2) @(negedge link_ck);
   endtask : wake
   // the bench calls this between scenarios, well inside the average interval
   task refresh();
      cmd(4'b0001, 3'h0, 16'h0000);
   endtask : refresh
endmodule : dcap_ctl

// [dcap_order.sv]
/*
 dcap_order: column order inside a burst for two successive beats.
 assumes: beat is even; start holds the low three column bits.
*/
module dcap_order
(
   input wire logic [2:0] start,
   input wire logic [2:0] beat,
   input wire logic interleave,
   output logic [2:0] col_a,
   output logic [2:0] col_b
);
   function automatic logic [2:0] order(input logic [2:0] s, input logic [2:0] i,
                                        input logic il);
      logic [1:0] low;
      low = s[1:0] + i[1:0];
      // sequential wraps inside the nibble, interleave is an xor
      order = il ? (s ^ i) : {s[2] ^ i[2], low};
   endfunction : order

   assign col_a = order(start, beat, interleave);
   assign col_b = order(start, beat | 3'h1, interleave);
endmodule : dcap_order

// [dcap_pkg.sv]
/*
 dcap_pkg: command codes, column engine and power states.
 assumes: dcap_regs.svh sits in the same folder.
*/
package dcap_pkg;
`include "dcap_regs.svh"
   // command code is {cs_n, ras_n, cas_n, we_n}
   typedef enum logic [3:0] {
      CMD_MRS = 4'b0000,
      CMD_REF = 4'b0001,
      CMD_PRE = 4'b0010,
      CMD_ACT = 4'b0011,
      CMD_WR = 4'b0100,
      CMD_RD = 4'b0101,
      CMD_NOP = 4'b0111
   } dcap_cmd_t;
   typedef enum logic [1:0] {
      COL_IDLE = 2'b00,
      COL_WAIT = 2'b01,
      COL_BURST = 2'b10
   } dcap_col_st_t;
   typedef enum logic [1:0] {
      PWR_ACTIVE = 2'b00,
      PWR_PD = 2'b01,
      PWR_SR = 2'b10
   } dcap_pwr_t;
endpackage : dcap_pkg

// [dcap_regs.svh]
/*
 dcap_regs.svh: named constants of the dram command/address port
 (address bit roles, mode register fields, burst beat limits).
 assumes: included by bare name from the package and the design files.
*/
`ifndef DCAP_REGS_SVH
`define DCAP_REGS_SVH

`define DCAP_BANKS 8
`define DCAP_AP_BIT 10
`define DCAP_BC_BIT 12
`define DCAP_COL_HI_BIT 11
`define DCAP_MR_SEL_MR0 3'h0
`define DCAP_MR_SEL_MR1 3'h1
`define DCAP_MR_RST 16'h0000
`define DCAP_BL_MSB 1
`define DCAP_BL_LSB 0
`define DCAP_BT_BIT 3
`define DCAP_AL_MSB 4
`define DCAP_AL_LSB 3
`define DCAP_BL_FIX8 2'h0
`define DCAP_BL_OTF 2'h1
`define DCAP_BL_FIX4 2'h2
`define DCAP_AL_ZERO 2'h0
`define DCAP_AL_CLM1 2'h1
`define DCAP_AL_CLM2 2'h2
`define DCAP_BEAT_STEP 3'h2
`define DCAP_BEAT_LAST8 3'h6
`define DCAP_BEAT_LAST4 3'h2
`define DCAP_LAT_W 6

`endif

// [dcap_top.sv]
/*
 dcap_top: command/address front end of an eight bank, byte wide ddr3
 dram, with a small backing array and double rate read/write bursts.
 assumes: link_ck is the controller's clock; the pins are in its domain.
 ref_clk side only reports bank and power state.
*/
`include "dcap_regs.svh"
module dcap_top
   import dcap_pkg::*;
#(
   parameter int CL = 5,
   parameter int CWL = 5,
   parameter int ROW_W = 2
)
(
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic link_ck,
   input wire logic cke,
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic [2:0] ba,
   input wire logic [15:0] addr,
   input wire logic [7:0] dq_i,
   output logic [7:0] dq_o,
   output logic dq_oe,
   input wire logic dqs_i,
   output logic dqs_o,
   output logic dqs_n_o,
   output logic dqs_oe,
   output logic [`DCAP_BANKS-1:0] bank_open_o,
   output logic pwr_pd_o,
   output logic pwr_sr_o
);
   import dcap_pkg::*;

   localparam int COL_W = 11;
   localparam int IDX_W = 3 + ROW_W + COL_W;
   localparam logic [`DCAP_LAT_W-1:0] CL_V = CL[`DCAP_LAT_W-1:0];
   localparam logic [`DCAP_LAT_W-1:0] CWL_V = CWL[`DCAP_LAT_W-1:0];

   generate
      if (CL < 3 || CL > 20 || CWL < 1 || CWL > 20 || ROW_W < 1 || ROW_W > 16)
      begin : g_bad
         $error("dcap_top: latency or row width out of range");
      end
   endgenerate

   function automatic logic [`DCAP_LAT_W-1:0] add_lat(input logic [1:0] al,
                                                      input logic [`DCAP_LAT_W-1:0] base);
      logic [`DCAP_LAT_W-1:0] extra;
      case (al)
         `DCAP_AL_CLM1: extra = CL_V - `DCAP_LAT_W'(1);
         `DCAP_AL_CLM2: extra = CL_V - `DCAP_LAT_W'(2);
         default: extra = '0;
      endcase
      add_lat = extra + base;
   endfunction : add_lat

   function automatic logic [IDX_W-1:0] mem_idx(input logic [2:0] b,
                                                input logic [ROW_W-1:0] r,
                                                input logic [COL_W-1:0] c,
                                                input logic [2:0] lo);
      mem_idx = {b, r, c[COL_W-1:3], lo};
   endfunction : mem_idx

   // link domain reset, from the core reset through two flops
   logic lrst_s1_ff;
   logic lrst_n_ff;
   always_ff @(posedge link_ck)
   begin
      lrst_s1_ff <= rstn;
      lrst_n_ff <= lrst_s1_ff;
   end

   // link state
   logic cke_q_ff;
   dcap_pwr_t pwr_ff;
   logic [`DCAP_BANKS-1:0] bank_open_ff;
   logic [15:0] row_ff [`DCAP_BANKS];
   logic [15:0] mr0_ff;
   logic [15:0] mr1_ff;
   dcap_col_st_t col_st_ff;
   logic [`DCAP_LAT_W-1:0] wait_ff;
   logic [2:0] beat_ff;
   logic is_wr_ff;
   logic ap_ff;
   logic len8_ff;
   logic [2:0] bank_ff;
   logic [ROW_W-1:0] row_lo_ff;
   logic [COL_W-1:0] col_ff;
   logic oe_ff;
   logic [7:0] dq_pos_ff;
   logic [7:0] dq_neg_ff;
   logic [7:0] wpos_ff;
   logic [7:0] wneg_ff;
   logic pend_ff;
   logic [2:0] pend_beat_ff;
   logic [7:0] mem [1 << IDX_W];

   // the internal clock runs for the cycle after a high cke
   wire run = cke_q_ff;
   wire take = run & cke;
   wire [3:0] cmd_w = {cs_n, ras_n, cas_n, we_n};
   // cs_n high never matches a code, so the command is masked
   wire is_mrs = take & (cmd_w == CMD_MRS);
   wire is_act = take & (cmd_w == CMD_ACT);
   wire is_pre = take & (cmd_w == CMD_PRE);
   wire is_rd = take & (cmd_w == CMD_RD);
   wire is_wr = take & (cmd_w == CMD_WR);
   wire is_col = (is_rd | is_wr) & (col_st_ff == COL_IDLE);
   wire all_idle = (bank_open_ff == '0) & (col_st_ff == COL_IDLE);
   wire lp_entry = run & ~cke & all_idle;
   wire sr_req = ~cs_n & ~ras_n & ~cas_n & we_n;
   wire [1:0] bl_w = mr0_ff[`DCAP_BL_MSB:`DCAP_BL_LSB];
   wire len8_w = (bl_w == `DCAP_BL_FIX8) |
                 ((bl_w == `DCAP_BL_OTF) & addr[`DCAP_BC_BIT]);
   wire [1:0] al_w = mr1_ff[`DCAP_AL_MSB:`DCAP_AL_LSB];
   wire [`DCAP_LAT_W-1:0] lat_w = add_lat(al_w, is_wr ? CWL_V : CL_V);
   wire [COL_W-1:0] col_w = {addr[`DCAP_COL_HI_BIT], addr[9:0]};
   wire [2:0] last_beat = len8_ff ? `DCAP_BEAT_LAST8 : `DCAP_BEAT_LAST4;
   wire burst_end = (col_st_ff == COL_BURST) & (beat_ff == last_beat);
   wire [2:0] ord_beat = is_wr_ff ? pend_beat_ff : beat_ff;
   wire [2:0] col_a;
   wire [2:0] col_b;
   wire [IDX_W-1:0] idx_a = mem_idx(bank_ff, row_lo_ff, col_ff, col_a);
   wire [IDX_W-1:0] idx_b = mem_idx(bank_ff, row_lo_ff, col_ff, col_b);

   dcap_order u_order
   (
      .start(col_ff[2:0]),
      .beat(ord_beat),
      .interleave(mr0_ff[`DCAP_BT_BIT]),
      .col_a(col_a),
      .col_b(col_b)
   );

   always_ff @(posedge link_ck)
   begin
      if (!lrst_n_ff)
         cke_q_ff <= 1'b0;
      else
         cke_q_ff <= cke;
   end

   always_ff @(posedge link_ck)
   begin
      if (!lrst_n_ff)
         pwr_ff <= PWR_ACTIVE;
      else if (cke)
         pwr_ff <= PWR_ACTIVE;
      else if (lp_entry)
         pwr_ff <= sr_req ? PWR_SR : PWR_PD;
   end

   always_ff @(posedge link_ck)
   begin
      if (!lrst_n_ff)
      begin
         bank_open_ff <= '0;
         mr0_ff <= `DCAP_MR_RST;
         mr1_ff <= `DCAP_MR_RST;
      end
      else if (run)
      begin
         if (is_mrs && ba == `DCAP_MR_SEL_MR0)
            mr0_ff <= addr;
         if (is_mrs && ba == `DCAP_MR_SEL_MR1)
            mr1_ff <= addr;
         if (is_act)
            bank_open_ff[ba] <= 1'b1;
         if (is_pre && addr[`DCAP_AP_BIT])
            bank_open_ff <= '0;
         else if (is_pre)
            bank_open_ff[ba] <= 1'b0;
         if (burst_end && ap_ff)
            bank_open_ff[bank_ff] <= 1'b0;
      end
   end

   always_ff @(posedge link_ck)
   begin
      if (run && is_act)
         row_ff[ba] <= addr;
   end

   // column engine; a column command while busy is dropped
   always_ff @(posedge link_ck)
   begin
      if (!lrst_n_ff)
      begin
         col_st_ff <= COL_IDLE;
         wait_ff <= '0;
         beat_ff <= '0;
         is_wr_ff <= 1'b0;
         ap_ff <= 1'b0;
         len8_ff <= 1'b0;
         bank_ff <= '0;
         row_lo_ff <= '0;
         col_ff <= '0;
      end
      else if (run)
      begin
         case (col_st_ff)
            COL_IDLE:
               if (is_col)
               begin
                  col_st_ff <= COL_WAIT;
                  wait_ff <= lat_w - `DCAP_LAT_W'(1);
                  is_wr_ff <= is_wr;
                  ap_ff <= addr[`DCAP_AP_BIT];
                  len8_ff <= len8_w;
                  bank_ff <= ba;
                  row_lo_ff <= row_ff[ba][ROW_W-1:0];
                  col_ff <= col_w;
               end
            COL_WAIT:
               if (wait_ff == '0)
               begin
                  col_st_ff <= COL_BURST;
                  beat_ff <= '0;
               end
               else
                  wait_ff <= wait_ff - `DCAP_LAT_W'(1);
            COL_BURST:
               if (burst_end)
                  col_st_ff <= COL_IDLE;
               else
                  beat_ff <= beat_ff + `DCAP_BEAT_STEP;
            default:
               col_st_ff <= COL_IDLE;
         endcase
      end
   end

   // read path: two words per cycle, shown on the two clock phases
   always_ff @(posedge link_ck)
   begin
      if (!lrst_n_ff)
         oe_ff <= 1'b0;
      else if (run)
         oe_ff <= (col_st_ff == COL_BURST) & ~is_wr_ff;
   end

   // cleared so a freeze right after reset holds known values
   always_ff @(posedge link_ck)
   begin
      if (!lrst_n_ff)
      begin
         dq_pos_ff <= '0;
         dq_neg_ff <= '0;
      end
      else if (run && col_st_ff == COL_BURST && !is_wr_ff)
      begin
         dq_pos_ff <= mem[idx_a];
         dq_neg_ff <= mem[idx_b];
      end
   end

   // write path: even beat on the rising edge, odd beat on the falling one;
   // strobe edges are assumed centred on link_ck, so dqs_i is not used
   always_ff @(negedge link_ck)
   begin
      wneg_ff <= dq_i;
   end

   always_ff @(posedge link_ck)
   begin
      if (!lrst_n_ff)
      begin
         pend_ff <= 1'b0;
         pend_beat_ff <= '0;
      end
      else if (run)
      begin
         pend_ff <= (col_st_ff == COL_BURST) & is_wr_ff;
         pend_beat_ff <= beat_ff;
      end
   end

   always_ff @(posedge link_ck)
   begin
      if (run && col_st_ff == COL_BURST && is_wr_ff)
         wpos_ff <= dq_i;
      if (run && pend_ff)
      begin
         mem[idx_a] <= wpos_ff;
         mem[idx_b] <= wneg_ff;
      end
   end

   // double rate output needs the phase select; the strobe follows the clock
   assign dq_o = link_ck ? dq_pos_ff : dq_neg_ff;
   assign dq_oe = oe_ff;
   assign dqs_o = oe_ff & link_ck;
   assign dqs_n_o = oe_ff & ~link_ck;
   assign dqs_oe = oe_ff;

   // core domain: status levels cross through two flops each
   logic rst_s1_ff;
   logic rst_n_ff;
   logic [`DCAP_BANKS+1:0] st_s1_ff;
   logic [`DCAP_BANKS+1:0] st_s2_ff;
   wire [`DCAP_BANKS+1:0] st_w = {pwr_ff == PWR_SR, pwr_ff == PWR_PD, bank_open_ff};

   always_ff @(posedge ref_clk)
   begin
      rst_s1_ff <= rstn;
      rst_n_ff <= rst_s1_ff;
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n_ff)
      begin
         st_s1_ff <= '0;
         st_s2_ff <= '0;
         bank_open_o <= '0;
         pwr_pd_o <= 1'b0;
         pwr_sr_o <= 1'b0;
      end
      else if (ce)
      begin
         st_s1_ff <= st_w;
         st_s2_ff <= st_s1_ff;
         bank_open_o <= st_s2_ff[`DCAP_BANKS-1:0];
         pwr_pd_o <= st_s2_ff[`DCAP_BANKS];
         pwr_sr_o <= st_s2_ff[`DCAP_BANKS+1];
      end
   end

   sequence s_burst8;
      (col_st_ff == COL_BURST)[*4];
   endsequence
   sequence s_act_done;
      ##1 bank_open_ff[$past(ba)] && row_ff[$past(ba)] == $past(addr);
   endsequence

   AST_CS_MASK: assert property (@(posedge link_ck) disable iff (!lrst_n_ff)
      (cs_n && col_st_ff == COL_IDLE && run) |=> col_st_ff == COL_IDLE)
      else $error("command taken with chip select high");
   AST_ACT_ROW: assert property (@(posedge link_ck) disable iff (!lrst_n_ff)
      is_act |-> s_act_done)
      else $error("activate did not open bank with full row");
   AST_PRE_BANK: assert property (@(posedge link_ck) disable iff (!lrst_n_ff)
      (is_pre && !addr[`DCAP_AP_BIT] && !(is_act)) |=> !bank_open_ff[$past(ba)])
      else $error("precharge left bank open");
   AST_SUSPEND: assert property (@(posedge link_ck) disable iff (!lrst_n_ff)
      !cke |=> !run)
      else $error("internal clock not suspended after low cke");
   AST_FREEZE: assert property (@(posedge link_ck) disable iff (!lrst_n_ff)
      !run |=> $stable(beat_ff) && $stable(dq_pos_ff) && $stable(oe_ff))
      else $error("state changed while suspended");
   AST_LOW_PWR: assert property (@(posedge link_ck) disable iff (!lrst_n_ff)
      (lp_entry && !sr_req) |=> pwr_ff == PWR_PD)
      else $error("power down not entered with all banks idle");
   AST_BL8: assert property (@(posedge link_ck) disable iff (!lrst_n_ff)
      ($rose(col_st_ff == COL_BURST) && len8_ff) |-> s_burst8)
      else $error("eight word burst shorter than four cycles");
   AST_COL_ADDR: assert property (@(posedge link_ck) disable iff (!lrst_n_ff)
      (is_col && run) |=> col_ff == {$past(addr[`DCAP_COL_HI_BIT]), $past(addr[9:0])})
      else $error("column address taken from wrong bits");
   AST_MRS: assert property (@(posedge link_ck) disable iff (!lrst_n_ff)
      (is_mrs && ba == `DCAP_MR_SEL_MR0) |=> mr0_ff == $past(addr))
      else $error("mode register did not load op-code");
   AST_AUTO_PRE: assert property (@(posedge link_ck) disable iff (!lrst_n_ff)
      (run && burst_end && ap_ff && !is_act) |=> !bank_open_ff[$past(bank_ff)])
      else $error("auto precharge left bank open");
   AST_ORDER: assert property (@(posedge link_ck) disable iff (!lrst_n_ff)
      (col_st_ff == COL_BURST && !is_wr_ff && mr0_ff[`DCAP_BT_BIT])
         |-> col_a == (col_ff[2:0] ^ beat_ff))
      else $error("interleaved order wrong");
   AST_RD_OE: assert property (@(posedge link_ck) disable iff (!lrst_n_ff)
      (run && col_st_ff == COL_BURST && !is_wr_ff) |=> oe_ff)
      else $error("read strobe not driven during burst");
endmodule : dcap_top

// [dcap_top_test.sv]
/*
 dcap_top_test: self-checking bench for dcap_top with a controller model.
 assumes: dcap_pkg and dcap_ctl are compiled first.
*/
module dcap_top_test;
   import dcap_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;
   logic ref_clk, rstn, ce, link_ck, cke, cs_n, ras_n, cas_n, we_n;
   logic dq_oe, dqs_i, dqs_o, dqs_n_o, dqs_oe, pwr_pd_o, pwr_sr_o;
   logic [2:0] ba;
   logic [15:0] addr;
   logic [7:0] dq_i, dq_o, bank_open_o;
   int n_fail, compares;
   dcap_top #(.CL(5), .CWL(5), .ROW_W(2)) dcap_top_i (.ref_clk(ref_clk), .rstn(rstn),
      .ce(ce), .link_ck(link_ck), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
      .we_n(we_n), .ba(ba), .addr(addr), .dq_i(dq_i), .dq_o(dq_o), .dq_oe(dq_oe),
      .dqs_i(dqs_i), .dqs_o(dqs_o), .dqs_n_o(dqs_n_o), .dqs_oe(dqs_oe),
      .bank_open_o(bank_open_o), .pwr_pd_o(pwr_pd_o), .pwr_sr_o(pwr_sr_o));
   dcap_ctl dcap_ctl_i (.link_ck(link_ck), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
      .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .dq_i(dq_i), .dqs_i(dqs_i),
      .dq_o(dq_o), .dq_oe(dq_oe));
   initial
   begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   initial
   begin
      link_ck = 1'b0;
      #3.1;
      forever #24 link_ck = ~link_ck;
   end
   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp)
      begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   function automatic logic [2:0] ord(input logic [2:0] s, input logic [2:0] k, input logic il);
      return il ? (s ^ k) : {s[2] ^ k[2], s[1:0] + k[1:0]};
   endfunction : ord
   task rdchk(input logic [15:0] a, input int nw, input logic il, input logic [7:0] b0,
      input int lat_x);
      int lat, n;
      logic [7:0] w [16];
      dcap_ctl_i.rd(3'h1, a, 0, lat, n, w);
      chk("read latency", lat_x, lat);
      chk("read words", nw, n);
      for (int i = 0; i < nw; i++)
         chk("read data", b0 + {5'h0, ord(a[2:0], i[2:0], il)}, w[i]);
   endtask : rdchk
   task t_banks();
      for (int b = 0; b < 8; b++)
      begin
         dcap_ctl_i.cmd(CMD_ACT, b[2:0], 16'hFFFF);
         @(negedge link_ck);
         chk("bank open", (2 << b) - 1, bank_open_o);
      end
      dcap_ctl_i.cmd(4'b1010, 3'h0, 16'h0400);
      @(negedge link_ck);
      chk("masked precharge", 32'hFF, bank_open_o);
      dcap_ctl_i.cmd(CMD_PRE, 3'h2, 16'h0000);
      @(negedge link_ck);
      chk("precharge one", 32'hFB, bank_open_o);
      dcap_ctl_i.cmd(CMD_PRE, 3'h0, 16'h0400);
      @(negedge link_ck);
      chk("precharge all", 32'h00, bank_open_o);
      @(negedge ref_clk);
      ce = 1'b0;
      dcap_ctl_i.cmd(CMD_ACT, 3'h3, 16'h0000);
      @(negedge link_ck);
      chk("status frozen by ce", 32'h00, bank_open_o);
      @(negedge ref_clk);
      ce = 1'b1;
      repeat (2) @(negedge link_ck);
      chk("status resumes with ce", 32'h08, bank_open_o);
      dcap_ctl_i.cmd(CMD_PRE, 3'h3, 16'h0000);
   endtask : t_banks
   task t_rw();
      logic [7:0] d [8];
      logic [7:0] e [8];
      for (int i = 0; i < 8; i++)
      begin
         d[i] = 8'hA0 + 8'(i);
         e[i] = 8'h50 + 8'(i);
      end
      dcap_ctl_i.cmd(CMD_ACT, 3'h1, 16'h0000);
      dcap_ctl_i.wr(3'h1, 16'h1000, d);
      dcap_ctl_i.wr(3'h1, 16'h1800, e);
      rdchk(16'h1000, 8, 1'b0, 8'hA0, 6);
      rdchk(16'h1800, 8, 1'b0, 8'h50, 6);
      rdchk(16'h1001, 8, 1'b0, 8'hA0, 6);
      dcap_ctl_i.cmd(CMD_MRS, 3'h0, 16'h0008);
      rdchk(16'h1001, 8, 1'b1, 8'hA0, 6);
      dcap_ctl_i.cmd(CMD_MRS, 3'h0, 16'h0002);
      rdchk(16'h1001, 4, 1'b0, 8'hA0, 6);
      dcap_ctl_i.cmd(CMD_MRS, 3'h0, 16'h0001);
      rdchk(16'h0001, 4, 1'b0, 8'hA0, 6);
      rdchk(16'h1001, 8, 1'b0, 8'hA0, 6);
      dcap_ctl_i.cmd(CMD_MRS, 3'h0, 16'h0000);
      // dq_oe rises (cl - al) + cl + 1 rises after the read, with cl = 5
      for (int al = 1; al < 3; al++)
      begin
         dcap_ctl_i.cmd(CMD_MRS, 3'h1, 16'(al << 3));
         rdchk(16'h1000, 8, 1'b0, 8'hA0, 11 - al);
      end
      dcap_ctl_i.cmd(CMD_MRS, 3'h1, 16'h0000);
   endtask : t_rw
   task t_dqs();
      dcap_ctl_i.cmd(CMD_RD, 3'h1, 16'h1000);
      repeat (6) @(posedge link_ck);
      #12;
      chk("strobe high phase", 32'h6A0, {dqs_oe, dqs_o, dqs_n_o, dq_o});
      @(negedge link_ck);
      #12;
      chk("strobe low phase", 32'h5A1, {dqs_oe, dqs_o, dqs_n_o, dq_o});
      repeat (6) @(negedge link_ck);
      chk("strobe released", 32'h0, {dqs_oe, dqs_o, dqs_n_o});
   endtask : t_dqs
   task t_frz();
      int lat, n;
      logic [7:0] w [16];
      dcap_ctl_i.rd(3'h1, 16'h1000, 3, lat, n, w);
      chk("frozen burst words", 14, n);
      chk("frozen burst tail", 8'hA7, w[13]);
      rdchk(16'h1400, 8, 1'b0, 8'hA0, 6);
      @(negedge link_ck);
      chk("auto precharge", 32'h00, bank_open_o);
   endtask : t_frz
   task t_pwr();
      dcap_ctl_i.cmd(CMD_ACT, 3'h4, 16'h0000);
      dcap_ctl_i.sleep(CMD_NOP);
      repeat (3) @(negedge link_ck);
      chk("no power down with open bank", 2'b00, {pwr_pd_o, pwr_sr_o});
      dcap_ctl_i.wake();
      dcap_ctl_i.cmd(CMD_PRE, 3'h4, 16'h0000);
      dcap_ctl_i.sleep(CMD_NOP);
      repeat (3) @(negedge link_ck);
      chk("power down", 2'b10, {pwr_pd_o, pwr_sr_o});
      dcap_ctl_i.wake();
      chk("power down exit", 2'b00, {pwr_pd_o, pwr_sr_o});
      dcap_ctl_i.sleep(CMD_REF);
      repeat (3) @(negedge link_ck);
      chk("self refresh", 2'b01, {pwr_pd_o, pwr_sr_o});
      dcap_ctl_i.wake();
      chk("self refresh exit", 2'b00, {pwr_pd_o, pwr_sr_o});
   endtask : t_pwr
   task results();
      if (n_fail == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : results
   // the run needs about 20 us; a hang ends it well past that
   initial
   begin
      #200000;
      n_fail++;
      results();
   end
   initial
   begin
      n_fail = 0;
      compares = 0;
      rstn = 1'b0;
      ce = 1'b1;
      // longer than 38 cycles: the link side needs four of its own edges in reset
      repeat (40) @(negedge ref_clk);
      rstn = 1'b1;
      repeat (4) @(negedge link_ck);
      chk("reset state", 32'h0, {bank_open_o, pwr_pd_o, pwr_sr_o, dq_oe});
      t_banks();
      dcap_ctl_i.refresh();
      t_rw();
      t_dqs();
      t_frz();
      dcap_ctl_i.refresh();
      @(negedge link_ck);
      chk("refresh ignored", 32'h0, {bank_open_o, pwr_pd_o, pwr_sr_o});
      t_pwr();
      results();
   end
endmodule : dcap_top_test
